// ---- logic/tmcl_pkg.sv ----
`default_nettype none
package tmcl_pkg;
    // ----------------------------------------
    // clock and conversion timing
    // ----------------------------------------
    localparam int CLK_HZ = 20_000_000;
    localparam int SLOW_PERIOD_MS = 1000;
    localparam int SLOW_PERIOD_CYC = CLK_HZ / 1000 * SLOW_PERIOD_MS;
    localparam int NCH = 4;
    localparam int TW = 11;
    localparam int CH_ONCHIP = 0;
    // ----------------------------------------
    // register indices (byte address is four times the index)
    // ----------------------------------------
    localparam logic [5:0] IDX_ONCHIP_HI = 6'h00;
    localparam logic [5:0] IDX_REMOTE1_HI = 6'h01;
    localparam logic [5:0] IDX_STATUS = 6'h02;
    localparam logic [5:0] IDX_CFG = 6'h03;
    localparam logic [5:0] IDX_RATE = 6'h04;
    localparam logic [5:0] IDX_ONCHIP_HLIM = 6'h05;
    localparam logic [5:0] IDX_ONCHIP_LLIM = 6'h06;
    localparam logic [5:0] IDX_R1_HLIM_INT = 6'h07;
    localparam logic [5:0] IDX_R1_LLIM_INT = 6'h08;
    localparam logic [5:0] IDX_CFG_ALT = 6'h09;
    localparam logic [5:0] IDX_RATE_ALT = 6'h0A;
    localparam logic [5:0] IDX_ONCHIP_HLIM_ALT = 6'h0B;
    localparam logic [5:0] IDX_ONCHIP_LLIM_ALT = 6'h0C;
    localparam logic [5:0] IDX_R1_HLIM_INT_ALT = 6'h0D;
    localparam logic [5:0] IDX_R1_LLIM_INT_ALT = 6'h0E;
    localparam logic [5:0] IDX_REMOTE1_LO = 6'h10;
    localparam logic [5:0] IDX_R1_HLIM_FRAC = 6'h13;
    localparam logic [5:0] IDX_R1_LLIM_FRAC = 6'h14;
    localparam logic [5:0] IDX_R2_HLIM_INT = 6'h15;
    localparam logic [5:0] IDX_R2_LLIM_INT = 6'h16;
    localparam logic [5:0] IDX_R2_HLIM_FRAC = 6'h17;
    localparam logic [5:0] IDX_R2_LLIM_FRAC = 6'h18;
    localparam logic [5:0] IDX_REMOTE2_HI = 6'h23;
    localparam logic [5:0] IDX_REMOTE2_LO = 6'h24;
    localparam logic [5:0] IDX_BETA2 = 6'h26;
    localparam logic [5:0] IDX_ONCHIP_LO = 6'h29;
    localparam logic [5:0] IDX_REMOTE3_HI = 6'h2A;
    localparam logic [5:0] IDX_REMOTE3_LO = 6'h2B;
    localparam logic [5:0] IDX_R3_HLIM_INT = 6'h2C;
    localparam logic [5:0] IDX_R3_LLIM_INT = 6'h2D;
    localparam logic [5:0] IDX_R3_HLIM_FRAC = 6'h2E;
    localparam logic [5:0] IDX_R3_LLIM_FRAC = 6'h2F;
    localparam logic [5:0] IDX_HI_STAT = 6'h35;
    localparam logic [5:0] IDX_LO_STAT = 6'h36;
    // ----------------------------------------
    // reset values and field layout
    // ----------------------------------------
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] CFG_WMASK = 8'hAF;
    localparam logic [7:0] RATE_RESET = 8'h06;
    localparam logic [7:0] RATE_WMASK = 8'h0F;
    localparam logic [7:0] HLIM_RESET = 8'h55;
    localparam logic [7:0] LLIM_RESET = 8'h00;
    localparam logic [7:0] FRAC_RESET = 8'h00;
    localparam logic [7:0] FRAC_WMASK = 8'hE0;
    localparam logic [7:0] BETA2_RESET = 8'h08;
    localparam int CFG_MASK_ALL = 7;
    localparam int CFG_COMP = 5;
    localparam int CFG_RECD = 3;
    localparam int CFG_RANGE = 2;
    localparam int CFG_DAVG = 1;
    localparam int CFG_ANTIPARALLEL_PAIR_DISABLE = 0;
    localparam int STAT_BUSY = 7;
    localparam int STAT_HIGH = 4;
    localparam int STAT_LOW = 3;
    // ----------------------------------------
    // bus states and helpers
    // ----------------------------------------
    typedef enum logic [1:0] {TMCL_IDLE = 2'b01, TMCL_ACK = 2'b10} tmcl_bus_t;

    // log2 of conversions per second for a rate code
    function automatic logic [2:0] rate_shift(input logic [3:0] code);
        logic [2:0] s;
        s = 3'd0;
        if (code >= 4'h5 && code <= 4'hA) begin
            s = 3'(code - 4'h4);
        end
        return s;
    endfunction

    // 11-bit limit from integer byte and left-justified fraction
    function automatic logic [10:0] limit11(input logic [7:0] int_b, input logic [7:0] frac_b);
        return {int_b, frac_b[7:5]};
    endfunction
endpackage
`default_nettype wire

// ---- logic/tmcl_cmp_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface tmcl_cmp_if;
    logic [3:0][10:0] reading;
    logic [3:0][10:0] high_lim;
    logic [3:0][10:0] low_lim;
    logic [3:0] above;
    logic [3:0] at_or_below;
    modport ctrl(output reading, output high_lim, output low_lim, input above, input at_or_below);
    modport cmp(input reading, input high_lim, input low_lim, output above, output at_or_below);
endinterface
`default_nettype wire

// ---- logic/tmcl_compare.sv ----
`timescale 1ns/1ps
`default_nettype none
module tmcl_compare (
    tmcl_cmp_if.cmp cif
);
    import tmcl_pkg::*;

    // ----------------------------------------
    // per-channel limit comparison
    // ----------------------------------------
    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            cif.above[c] = cif.reading[c] > cif.high_lim[c];
            cif.at_or_below[c] = cif.reading[c] <= cif.low_lim[c];
        end
    end
endmodule
`default_nettype wire

// ---- logic/tmcl_top.sv ----
// What this block does
// - configuration register answers at two addresses, one storage.
// - mask-all bit holds alert off in interrupt mode; else set status asserts alert.
// - status flags keep updating while alert is masked.
// - comparator-mode bit drives alert as comparator and ignores mask-all.
// - bit 3 set turns series resistance correction off on remote 2 and 3.
// - range bit picks plain binary or offset binary extended range.
// - averaging-off bit caps averaging at 1x, else rate picks averaging.
// - bit 0 selects one or two anti-parallel diodes on remote 2 pins.
// - beta compensation off on remote 2 and 3; remote 2 beta register ignored.
// - rate register at two addresses, 4-bit code, resets to 06h.
// - rate codes map to 1..64 conversions per second; Bh-Fh give one.
// - each conversion updates all channel results then compares against limits.
// - reading above high limit sets that channel's high flag.
// - reading at or below low limit sets that channel's low flag.
// - aliased limit registers are fully accessible at either address.
// - high and low limit per channel; remote channels add 3 fraction bits.
// - reading a limit status register clears it and its summary bit.
// - readings kept as 11 bits, integer high byte, fraction left-justified.
`timescale 1ns/1ps
`default_nettype none
module tmcl_top #(
    parameter int unsigned CONV_BASE_CYCLES = tmcl_pkg::SLOW_PERIOD_CYC
) (
    input wire logic REF_CLK,
    input wire logic RESET_N,
    input wire logic [7:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [3:0] AVS_BYTEENABLE,
    input wire logic [31:0] AVS_WRITEDATA,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire logic [tmcl_pkg::TW-1:0] TEMP_ONCHIP,
    input wire logic [tmcl_pkg::TW-1:0] TEMP_REMOTE1,
    input wire logic [tmcl_pkg::TW-1:0] TEMP_REMOTE2,
    input wire logic [tmcl_pkg::TW-1:0] TEMP_REMOTE3,
    output logic CONVERT_TICK,
    output logic ALERT_N,
    output logic EXTENDED_RANGE,
    output logic SERIES_RESISTANCE_FIX_OFF_CH23,
    output logic DYNAMIC_AVERAGING_OFF,
    output logic ANTIPARALLEL_PAIR_DISABLE,
    output logic BETA_COMP_CH23_EN,
    output logic [3:0] SAMPLE_RATE_CODE
);
    import tmcl_pkg::*;

    // ----------------------------------------
    // storage
    // ----------------------------------------
    tmcl_bus_t state_reg;
    logic wait_reg;
    logic [31:0] rdata_reg;
    logic [7:0] cfg_reg;
    logic [7:0] rate_reg;
    logic [7:0] beta2_reg;
    logic [7:0] hi_int_reg [NCH];
    logic [7:0] lo_int_reg [NCH];
    logic [7:0] hi_frac_reg [NCH];
    logic [7:0] lo_frac_reg [NCH];
    logic [TW-1:0] temp_reg [NCH];
    logic [3:0] hi_stat_reg;
    logic [3:0] lo_stat_reg;
    logic [3:0] oor_reg;
    logic [31:0] tick_cnt_reg;
    logic tick_reg;
    logic busy_reg;
    logic alert_n_reg;
    logic beta_en_reg;
    logic [7:0] rd_byte;
    logic [5:0] idx;
    logic aligned;
    logic wr_commit;
    logic rd_commit;
    logic [31:0] period;
    logic [3:0] hi_set;
    logic [3:0] lo_set;
    logic hi_clr;
    logic lo_clr;
    logic alert_next;

    tmcl_cmp_if cif ();

    tmcl_compare u_cmp (
        .cif(cif)
    );

    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    assign idx = AVS_ADDRESS[7:2];
    assign aligned = AVS_ADDRESS[1:0] == 2'b00;
    assign wr_commit = state_reg == TMCL_ACK && AVS_WRITE && AVS_BYTEENABLE[0] && aligned;
    assign rd_commit = state_reg == TMCL_ACK && AVS_READ && aligned;

    // ----------------------------------------
    // bus handshake, one wait cycle per access
    // ----------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            state_reg <= TMCL_IDLE;
            wait_reg <= 1'b1;
            rdata_reg <= 32'h0000_0000;
        end else begin
            unique case (state_reg)
                TMCL_IDLE: begin
                    if (AVS_READ || AVS_WRITE) begin
                        state_reg <= TMCL_ACK;
                        wait_reg <= 1'b0;
                        if (AVS_READ) begin
                            rdata_reg <= {24'h00_0000, rd_byte};
                        end
                    end
                end
                TMCL_ACK: begin
                    state_reg <= TMCL_IDLE;
                    wait_reg <= 1'b1;
                end
            endcase
        end
    end

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    always_comb begin
        rd_byte = 8'h00;
        if (aligned) begin
            unique case (idx)
                IDX_CFG, IDX_CFG_ALT: rd_byte = cfg_reg;
                IDX_RATE, IDX_RATE_ALT: rd_byte = rate_reg;
                IDX_ONCHIP_HLIM, IDX_ONCHIP_HLIM_ALT: rd_byte = hi_int_reg[0];
                IDX_ONCHIP_LLIM, IDX_ONCHIP_LLIM_ALT: rd_byte = lo_int_reg[0];
                IDX_R1_HLIM_INT, IDX_R1_HLIM_INT_ALT: rd_byte = hi_int_reg[1];
                IDX_R1_LLIM_INT, IDX_R1_LLIM_INT_ALT: rd_byte = lo_int_reg[1];
                IDX_R1_HLIM_FRAC: rd_byte = hi_frac_reg[1];
                IDX_R1_LLIM_FRAC: rd_byte = lo_frac_reg[1];
                IDX_R2_HLIM_INT: rd_byte = hi_int_reg[2];
                IDX_R2_LLIM_INT: rd_byte = lo_int_reg[2];
                IDX_R2_HLIM_FRAC: rd_byte = hi_frac_reg[2];
                IDX_R2_LLIM_FRAC: rd_byte = lo_frac_reg[2];
                IDX_R3_HLIM_INT: rd_byte = hi_int_reg[3];
                IDX_R3_LLIM_INT: rd_byte = lo_int_reg[3];
                IDX_R3_HLIM_FRAC: rd_byte = hi_frac_reg[3];
                IDX_R3_LLIM_FRAC: rd_byte = lo_frac_reg[3];
                IDX_ONCHIP_HI: rd_byte = temp_reg[0][10:3];
                IDX_ONCHIP_LO: rd_byte = {temp_reg[0][2:0], 5'h00};
                IDX_REMOTE1_HI: rd_byte = temp_reg[1][10:3];
                IDX_REMOTE1_LO: rd_byte = {temp_reg[1][2:0], 5'h00};
                IDX_REMOTE2_HI: rd_byte = temp_reg[2][10:3];
                IDX_REMOTE2_LO: rd_byte = {temp_reg[2][2:0], 5'h00};
                IDX_REMOTE3_HI: rd_byte = temp_reg[3][10:3];
                IDX_REMOTE3_LO: rd_byte = {temp_reg[3][2:0], 5'h00};
                IDX_BETA2: rd_byte = beta2_reg;
                IDX_STATUS: begin
                    rd_byte[STAT_BUSY] = busy_reg;
                    rd_byte[STAT_HIGH] = |hi_stat_reg;
                    rd_byte[STAT_LOW] = |lo_stat_reg;
                end
                IDX_HI_STAT: rd_byte = {4'h0, hi_stat_reg};
                IDX_LO_STAT: rd_byte = {4'h0, lo_stat_reg};
                default: rd_byte = 8'h00;
            endcase
        end
    end

    // ----------------------------------------
    // configuration and rate registers
    // ----------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            cfg_reg <= CFG_RESET;
        end else if (wr_commit && (idx == IDX_CFG || idx == IDX_CFG_ALT)) begin
            cfg_reg <= AVS_WRITEDATA[7:0] & CFG_WMASK;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            rate_reg <= RATE_RESET;
        end else if (wr_commit && (idx == IDX_RATE || idx == IDX_RATE_ALT)) begin
            rate_reg <= AVS_WRITEDATA[7:0] & RATE_WMASK;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            beta2_reg <= BETA2_RESET;
        end else if (wr_commit && idx == IDX_BETA2) begin
            beta2_reg <= AVS_WRITEDATA[7:0];
        end
    end

    // ----------------------------------------
    // limit registers
    // ----------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            for (int c = 0; c < NCH; c++) begin
                hi_int_reg[c] <= HLIM_RESET;
                lo_int_reg[c] <= LLIM_RESET;
                hi_frac_reg[c] <= FRAC_RESET;
                lo_frac_reg[c] <= FRAC_RESET;
            end
        end else if (wr_commit) begin
            unique case (idx)
                IDX_ONCHIP_HLIM, IDX_ONCHIP_HLIM_ALT: hi_int_reg[0] <= AVS_WRITEDATA[7:0];
                IDX_ONCHIP_LLIM, IDX_ONCHIP_LLIM_ALT: lo_int_reg[0] <= AVS_WRITEDATA[7:0];
                IDX_R1_HLIM_INT, IDX_R1_HLIM_INT_ALT: hi_int_reg[1] <= AVS_WRITEDATA[7:0];
                IDX_R1_LLIM_INT, IDX_R1_LLIM_INT_ALT: lo_int_reg[1] <= AVS_WRITEDATA[7:0];
                IDX_R2_HLIM_INT: hi_int_reg[2] <= AVS_WRITEDATA[7:0];
                IDX_R2_LLIM_INT: lo_int_reg[2] <= AVS_WRITEDATA[7:0];
                IDX_R3_HLIM_INT: hi_int_reg[3] <= AVS_WRITEDATA[7:0];
                IDX_R3_LLIM_INT: lo_int_reg[3] <= AVS_WRITEDATA[7:0];
                // fraction keeps bits 7 to 5 only
                IDX_R1_HLIM_FRAC: hi_frac_reg[1] <= AVS_WRITEDATA[7:0] & FRAC_WMASK;
                IDX_R1_LLIM_FRAC: lo_frac_reg[1] <= AVS_WRITEDATA[7:0] & FRAC_WMASK;
                IDX_R2_HLIM_FRAC: hi_frac_reg[2] <= AVS_WRITEDATA[7:0] & FRAC_WMASK;
                IDX_R2_LLIM_FRAC: lo_frac_reg[2] <= AVS_WRITEDATA[7:0] & FRAC_WMASK;
                IDX_R3_HLIM_FRAC: hi_frac_reg[3] <= AVS_WRITEDATA[7:0] & FRAC_WMASK;
                IDX_R3_LLIM_FRAC: lo_frac_reg[3] <= AVS_WRITEDATA[7:0] & FRAC_WMASK;
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------
    // conversion timer
    // ----------------------------------------
    // period shrinks by powers of two
    assign period = CONV_BASE_CYCLES >> rate_shift(rate_reg[3:0]);

    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            tick_cnt_reg <= 32'h0000_0000;
            tick_reg <= 1'b0;
        end else if (tick_cnt_reg + 32'h0000_0001 >= period) begin
            tick_cnt_reg <= 32'h0000_0000;
            tick_reg <= 1'b1;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
            tick_reg <= 1'b0;
        end
    end

    // latch all results, compare next cycle
    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            busy_reg <= 1'b0;
            for (int c = 0; c < NCH; c++) begin
                temp_reg[c] <= '0;
            end
        end else begin
            busy_reg <= tick_reg;
            if (tick_reg) begin
                temp_reg[0] <= TEMP_ONCHIP;
                temp_reg[1] <= TEMP_REMOTE1;
                temp_reg[2] <= TEMP_REMOTE2;
                temp_reg[3] <= TEMP_REMOTE3;
            end
        end
    end

    // ----------------------------------------
    // comparator feed
    // ----------------------------------------
    // unsigned compare serves both formats
    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            cif.reading[c] = temp_reg[c];
            if (c == CH_ONCHIP) begin
                cif.high_lim[c] = limit11(hi_int_reg[c], FRAC_RESET);
                cif.low_lim[c] = limit11(lo_int_reg[c], FRAC_RESET);
            end else begin
                cif.high_lim[c] = limit11(hi_int_reg[c], hi_frac_reg[c]);
                cif.low_lim[c] = limit11(lo_int_reg[c], lo_frac_reg[c]);
            end
        end
    end

    // ----------------------------------------
    // limit status, set wins over clear
    // ----------------------------------------
    assign hi_set = busy_reg ? cif.above : 4'h0;
    assign lo_set = busy_reg ? cif.at_or_below : 4'h0;
    assign hi_clr = rd_commit && idx == IDX_HI_STAT;
    assign lo_clr = rd_commit && idx == IDX_LO_STAT;

    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            hi_stat_reg <= 4'h0;
        end else begin
            hi_stat_reg <= (hi_stat_reg & ~(hi_clr ? rdata_reg[3:0] : 4'h0)) | hi_set;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            lo_stat_reg <= 4'h0;
        end else begin
            lo_stat_reg <= (lo_stat_reg & ~(lo_clr ? rdata_reg[3:0] : 4'h0)) | lo_set;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            oor_reg <= 4'h0;
        end else if (busy_reg) begin
            oor_reg <= cif.above | cif.at_or_below;
        end
    end

    // ----------------------------------------
    // alert output
    // ----------------------------------------
    always_comb begin
        if (cfg_reg[CFG_COMP]) begin
            alert_next = |oor_reg;
        end else begin
            alert_next = !cfg_reg[CFG_MASK_ALL] && (|hi_stat_reg || |lo_stat_reg);
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            alert_n_reg <= 1'b1;
        end else begin
            alert_n_reg <= !alert_next;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            beta_en_reg <= 1'b0;
        end else begin
            beta_en_reg <= 1'b0;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign AVS_READDATA = rdata_reg;
    assign AVS_WAITREQUEST = wait_reg;
    assign CONVERT_TICK = tick_reg;
    assign ALERT_N = alert_n_reg;
    assign EXTENDED_RANGE = cfg_reg[CFG_RANGE];
    // correction off for remote 2 and 3
    assign SERIES_RESISTANCE_FIX_OFF_CH23 = cfg_reg[CFG_RECD];
    assign DYNAMIC_AVERAGING_OFF = cfg_reg[CFG_DAVG];
    // one or two diodes on remote 2
    assign ANTIPARALLEL_PAIR_DISABLE = cfg_reg[CFG_ANTIPARALLEL_PAIR_DISABLE];
    assign BETA_COMP_CH23_EN = beta_en_reg;
    assign SAMPLE_RATE_CODE = rate_reg[3:0];
endmodule
`default_nettype wire

// ---- tb/tmcl_top_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module tmcl_top_asserts #(
    parameter int unsigned CONV_BASE_CYCLES = 640
) (
    input wire logic REF_CLK,
    input wire logic RESET_N,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_READDATA,
    input wire logic AVS_WAITREQUEST,
    input wire logic CONVERT_TICK,
    input wire logic ALERT_N,
    input wire logic EXTENDED_RANGE,
    input wire logic SERIES_RESISTANCE_FIX_OFF_CH23,
    input wire logic DYNAMIC_AVERAGING_OFF,
    input wire logic ANTIPARALLEL_PAIR_DISABLE,
    input wire logic BETA_COMP_CH23_EN,
    input wire logic [3:0] SAMPLE_RATE_CODE
);
    localparam int MIN_GAP = int'(CONV_BASE_CYCLES >> 6);
    logic [31:0] gap_reg;
    logic wr_ack;
    assign wr_ack = AVS_WRITE && !AVS_WAITREQUEST;
    // cycles since the last conversion tick
    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            gap_reg <= 32'(MIN_GAP);
        end else if (CONVERT_TICK) begin
            gap_reg <= 32'h0;
        end else begin
            gap_reg <= gap_reg + 32'h1;
        end
    end
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RESET_N);
    a_ack_after_req: assert property ($rose(AVS_READ || AVS_WRITE) |=> !AVS_WAITREQUEST)
        else $error("bus answer not one cycle after request");
    a_ack_one_cycle: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
        else $error("answer held longer than one cycle");
    a_read_upper_zero: assert property (AVS_READ && !AVS_WAITREQUEST |-> AVS_READDATA[31:8] == 24'h0)
        else $error("unused read bits not zero");
    a_beta_comp_off: assert property (BETA_COMP_CH23_EN == 1'b0)
        else $error("beta compensation enabled");
    a_tick_single: assert property (CONVERT_TICK |=> !CONVERT_TICK)
        else $error("conversion tick longer than one cycle");
    a_tick_spacing: assert property (CONVERT_TICK |-> gap_reg >= 32'(MIN_GAP - 1))
        else $error("conversion ticks too close");
    a_cfg_by_write: assert property ($changed({EXTENDED_RANGE, SERIES_RESISTANCE_FIX_OFF_CH23,
        DYNAMIC_AVERAGING_OFF, ANTIPARALLEL_PAIR_DISABLE}) |-> $past(wr_ack) || $past(wr_ack, 2))
        else $error("config output changed without a write");
    a_rate_by_write: assert property ($changed(SAMPLE_RATE_CODE) |-> $past(wr_ack) || $past(wr_ack, 2))
        else $error("rate code changed without a write");
    a_alert_cause: assert property ($fell(ALERT_N) |-> $past(CONVERT_TICK, 2) || $past(CONVERT_TICK, 3)
        || $past(wr_ack) || $past(wr_ack, 2) || $past(wr_ack, 3))
        else $error("alert asserted without conversion or write");
    c_tick: cover property (CONVERT_TICK);
    c_alert: cover property ($fell(ALERT_N));
    c_read: cover property (AVS_READ && !AVS_WAITREQUEST);
endmodule
bind tmcl_top tmcl_top_asserts #(.CONV_BASE_CYCLES(CONV_BASE_CYCLES)) i_tmcl_top_asserts (.REF_CLK, .RESET_N,
    .AVS_READ, .AVS_WRITE, .AVS_READDATA, .AVS_WAITREQUEST, .CONVERT_TICK, .ALERT_N, .EXTENDED_RANGE,
    .SERIES_RESISTANCE_FIX_OFF_CH23, .DYNAMIC_AVERAGING_OFF, .ANTIPARALLEL_PAIR_DISABLE, .BETA_COMP_CH23_EN,
    .SAMPLE_RATE_CODE);
`default_nettype wire

// ---- tb/tmcl_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module tmcl_host_model (
    input wire logic clk,
    input wire logic [31:0] rdata,
    input wire logic wait_req,
    output logic [7:0] addr,
    output logic rd_en,
    output logic wr_en,
    output logic [31:0] wdata,
    output logic hung
);
    initial begin
        {addr, rd_en, wr_en, wdata, hung} = '0;
    end
    // limit bytes go out as given, in the active format
    task automatic xfer(input logic is_wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        int n;
        @(posedge clk);
        {addr, wdata, rd_en, wr_en} <= {a, 24'h0, d, !is_wr, is_wr};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wait_req && n < 50);
        hung <= wait_req;
        q = rdata[7:0];
        {rd_en, wr_en} <= 2'b00;
    endtask
endmodule
`default_nettype wire

// ---- tb/tmcl_top_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tmcl_top_tb;
    localparam int unsigned BASE = 640;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0][10:0] temp = {4{11'h100}};
    logic [7:0] addr;
    logic rd_en;
    logic wr_en;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic wait_req;
    logic hung;
    logic tick;
    logic alert_n;
    logic [3:0] cfg_o;
    logic beta_en;
    logic [3:0] rate_o;
    logic [31:0] seed = 32'hc32e_0258;
    int n_errors = 0;
    int compares = 0;
    logic [10:0] hl [4] = '{11'h200, 11'h201, 11'h2a8, 11'h2a8};
    logic [10:0] ll [4] = '{11'h080, 11'h080, 11'h000, 11'h000};
    logic [31:0] tab [8] = '{32'h0c24_00af, 32'h1028_060f, 32'h142c_55ff, 32'h1830_00ff, 32'h1c34_55ff,
        32'h2038_00ff, 32'h5c5c_00e0, 32'hb0b0_55ff};
    always #25 clk = ~clk;
    tmcl_host_model i_tmcl_host_model (.clk(clk), .rdata(rdata), .wait_req(wait_req), .addr(addr),
        .rd_en(rd_en), .wr_en(wr_en), .wdata(wdata), .hung(hung));
    tmcl_top #(.CONV_BASE_CYCLES(BASE)) i_tmcl_top (.REF_CLK(clk), .RESET_N(rst_n), .AVS_ADDRESS(addr),
        .AVS_READ(rd_en), .AVS_WRITE(wr_en), .AVS_BYTEENABLE(4'h1), .AVS_WRITEDATA(wdata),
        .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_req), .TEMP_ONCHIP(temp[0]), .TEMP_REMOTE1(temp[1]),
        .TEMP_REMOTE2(temp[2]), .TEMP_REMOTE3(temp[3]), .CONVERT_TICK(tick), .ALERT_N(alert_n),
        .EXTENDED_RANGE(cfg_o[2]), .SERIES_RESISTANCE_FIX_OFF_CH23(cfg_o[3]), .DYNAMIC_AVERAGING_OFF(cfg_o[1]),
        .ANTIPARALLEL_PAIR_DISABLE(cfg_o[0]), .BETA_COMP_CH23_EN(beta_en), .SAMPLE_RATE_CODE(rate_o));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic int period(input logic [3:0] c);
        return (c >= 4'h5 && c <= 4'ha) ? int'(BASE >> (c - 4'h4)) : int'(BASE);
    endfunction
    task automatic conclude();
        if (n_errors == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        i_tmcl_host_model.xfer(1'b1, a, d, q);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
        logic [7:0] q;
        i_tmcl_host_model.xfer(1'b0, a, 8'h00, q);
        chk(q, exp, what);
    endtask
    task automatic tick_gap(output int n);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (!tick && n < 2000);
        if (!tick) begin
            n_errors++;
            conclude();
        end
    endtask
    always @(posedge hung) begin
        n_errors++;
        conclude();
    end
    initial begin
        int n;
        logic [31:0] e;
        logic [7:0] d;
        logic [7:0] cfg;
        logic [10:0] tv;
        logic [3:0] hi;
        logic [3:0] lo;
        logic [3:0] codes [5];
        codes = '{4'h0, 4'h5, 4'h6, 4'ha, 4'hb};
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        chk({alert_n, wait_req, cfg_o, rate_o}, 10'h306, "reset outputs");
        foreach (tab[i]) begin
            e = tab[i];
            rd_chk(e[31:24], e[15:8], "reset value");
            d = 8'(rnd());
            wr(e[31:24], d);
            rd_chk(e[23:16], d & e[7:0], "alias read");
            wr(e[31:24], e[15:8]);
        end
        wr(8'h98, 8'hff);
        wr(8'h24, 8'h0f);
        repeat (2) @(negedge clk);
        chk({beta_en, cfg_o}, 5'h0f, "config outputs");
        wr(8'h0c, 8'h05);
        repeat (2) @(negedge clk);
        chk(cfg_o, 4'h5, "config outputs");
        rd_chk(8'hfc, 8'h00, "unmapped");
        rd_chk(8'h0d, 8'h00, "unaligned");
        wr(8'h0c, 8'h00);
        foreach (codes[i]) begin
            wr(8'h28, {4'h0, codes[i]});
            tick_gap(n);
            tick_gap(n);
            chk({rate_o, 16'(n)}, {codes[i], 16'(period(codes[i]))}, "rate and period");
        end
        // limits in plain binary while range bit is clear
        wr(8'h14, 8'h40);
        wr(8'h18, 8'h10);
        wr(8'h1c, 8'h40);
        wr(8'h4c, 8'h20);
        wr(8'h20, 8'h10);
        i_tmcl_host_model.xfer(1'b0, 8'hd4, 8'h00, d);
        i_tmcl_host_model.xfer(1'b0, 8'hd8, 8'h00, d);
        repeat (8) begin
            cfg = 8'(rnd()) & 8'ha0;
            wr(8'h0c, cfg);
            @(posedge clk);
            for (int i = 0; i < 4; i++) begin
                tv = rnd() & 1 ? hl[i] + 11'(rnd() & 1) : ll[i] + 11'(rnd() & 1);
                hi[i] = tv > hl[i];
                lo[i] = tv <= ll[i];
                temp[i] <= tv;
            end
            tick_gap(n);
            tick_gap(n);
            repeat (3) @(negedge clk);
            chk(alert_n, !((cfg[5] || !cfg[7]) && |{hi, lo}), "alert");
            rd_chk(8'h08, {3'h0, |hi, |lo, 3'h0}, "summary");
            rd_chk(8'hd4, {4'h0, hi}, "high status");
            rd_chk(8'hd8, {4'h0, lo}, "low status");
            rd_chk(8'h08, 8'h00, "summary cleared");
            repeat (2) @(negedge clk);
            chk(alert_n, !(cfg[5] && |{hi, lo}), "alert after clear");
            rd_chk(8'ha8, tv[10:3], "remote3 high byte");
            rd_chk(8'hac, {tv[2:0], 5'h00}, "remote3 low byte");
        end
        conclude();
    end
endmodule
`default_nettype wire
